/* inc/ods_pkg.sv */
// Shared constants and types for the octal converter serial link
// ==========================================================
// Summary of operation
// - A frame is sixteen falling clocks, sync low
// - Sample data on each falling clock edge
// - Host never drops sync on falling edge
// - Last bit lands on sixteenth falling edge
// - Sync rising after full frame executes command
// - Host raises sync between edges sixteen, seventeen
// - Sync rising before sixteen aborts, nothing changes
// - Sync low past sixteen forwards data out
// - Host keeps sync high minimum time between frames
// - Host idles data input low
// - Host idles sync high
// - Eight channels, 12-bit straight binary codes
// - Mode decides immediate or deferred output update
// - Wake-up starts at sync rise; down means zero
// - Nibbles 1000/1001 pick mode; reset register-only
// - Top bit zero writes code to selected channel
// - Nibbles 1010, 1011, 1100 do group updates
// - Data out low, high at fifteen, then echo
package ods_pkg;
    // ==========================================================
    // Frame geometry
    localparam int          FRAME_BITS   = 16;
    localparam logic [4:0]  CNT_FULL     = 5'h10;
    localparam logic [4:0]  CNT_MARK     = 5'h0f;
    localparam logic [4:0]  CNT_MAX      = 5'h1f;
    localparam int          CMD_MSB      = 15;
    localparam int          CMD_LSB      = 12;
    localparam int          SEL_MSB      = 14;
    localparam int          SEL_LSB      = 12;
    localparam int          CODE_MSB     = 11;
    localparam int          PD_MASK_MSB  = 7;
    // ==========================================================
    // Command nibbles
    localparam logic [3:0]  CMD_REG_ONLY = 4'h8;
    localparam logic [3:0]  CMD_IMMEDIATE = 4'h9;
    localparam logic [3:0]  CMD_UPD_ALL  = 4'ha;
    localparam logic [3:0]  CMD_LOAD_A   = 4'hb;
    localparam logic [3:0]  CMD_BROADCAST = 4'hc;
    localparam logic [3:0]  CMD_PWR_DOWN = 4'hd;
    // ==========================================================
    // Reset values
    localparam logic        RST_IMM_MODE = 1'b0;
    localparam logic        RST_PWR_DOWN = 1'b1;
    // ==========================================================
    // Timing
    localparam int          CLK_NS       = 20;
    localparam int          SCLK_HALF_NS = 80;
    localparam int          SYNC_HIGH_NS = 15;
    localparam int          HALF_CYC     = SCLK_HALF_NS / CLK_NS;
    localparam int          SYNC_HIGH_CYC =
        ((SYNC_HIGH_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
        ((SYNC_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam int          GAP_HALVES   = 2;
    // ==========================================================
    // Host sequencer states
    typedef enum logic [2:0] {
        HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP
    } ods_host_st_t;
endpackage : ods_pkg

/* inc/ods_link_if.sv */
// Four-wire serial link between host and converter
`timescale 1ns/1ps
interface ods_link_if;
    logic sclk;
    logic sync_n;
    logic din;
    logic dout;
    modport host (output sclk, output sync_n, output din, input dout);
    modport dev  (input sclk, input sync_n, input din, output dout);
endinterface : ods_link_if

/* hdl/ods_dev.sv */
// Converter end: frame receiver, command executor and chain output
`timescale 1ns/1ps
module ods_dev #(
    parameter int CH = 8,
    parameter int CW = 12
) (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             SYS_RST,
    // Serial link
    ods_link_if.dev               LINK,
    // Channel state
    output logic [CH*CW-1:0]      LEVEL_OUT,
    output logic [CH-1:0]         PWR_DOWN,
    output logic [CH-1:0]         WAKE,
    output logic                  IMM_MODE,
    // Frame events
    output logic                  FRAME_DONE,
    output logic                  FRAME_ABORT
);
    // ==========================================================
    // Pin synchronisers
    logic sclk_s1, sclk_s2, sync_s1, sync_s2, din_s1, din_s2;

    // Two flops per pin; only the second stage is read by logic
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sync_s1 <= 1'b1;
            sync_s2 <= 1'b1;
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
        end else begin
            sclk_s1 <= LINK.sclk;
            sclk_s2 <= sclk_s1;
            sync_s1 <= LINK.sync_n;
            sync_s2 <= sync_s1;
            din_s1  <= LINK.din;
            din_s2  <= din_s1;
        end
    end

    // ==========================================================
    // Frame receiver
    logic        sclk_p_q, sclk_p_d;
    logic        sync_p_q, sync_p_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [15:0] shift_q, shift_d;
    logic        dout_q, dout_d;
    logic        done_q, done_d;
    logic        abort_q, abort_d;
    logic        fall, sync_fall, sync_rise, exec;
    logic [4:0]  cnt_next;

    // Edge finding and shifting; all three pins share equal delay
    always_comb begin
        sclk_p_d  = sclk_s2;
        sync_p_d  = sync_s2;
        cnt_d     = cnt_q;
        shift_d   = shift_q;
        dout_d    = dout_q;
        fall      = sclk_p_q && !sclk_s2 && !sync_s2;
        sync_fall = sync_p_q && !sync_s2;
        sync_rise = !sync_p_q && sync_s2;
        exec      = sync_rise && (cnt_q >= ods_pkg::CNT_FULL);
        done_d    = exec;
        abort_d   = sync_rise && (cnt_q < ods_pkg::CNT_FULL);
        // Count saturates so very long chained frames never wrap to a short one
        cnt_next  = (cnt_q == ods_pkg::CNT_MAX) ? cnt_q : cnt_q + 5'h01;
        if (sync_fall) begin
            cnt_d  = 5'h00;
            dout_d = 1'b0;
        end else if (fall) begin
            // MSB arrives first, so the word fills from the bottom
            shift_d = {shift_q[14:0], din_s2};
            cnt_d   = cnt_next;
            if (cnt_next < ods_pkg::CNT_MARK) begin
                dout_d = 1'b0;
            end else if (cnt_next == ods_pkg::CNT_MARK) begin
                dout_d = 1'b1;
            end else begin
                dout_d = shift_q[14];
            end
        end else if (sync_rise) begin
            // Chain output falls quiet once the frame ends
            dout_d = 1'b0;
        end
    end

    // Receiver registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sclk_p_q <= 1'b1;
            sync_p_q <= 1'b1;
            cnt_q    <= 5'h00;
            shift_q  <= 16'h0000;
            dout_q   <= 1'b0;
            done_q   <= 1'b0;
            abort_q  <= 1'b0;
        end else begin
            sclk_p_q <= sclk_p_d;
            sync_p_q <= sync_p_d;
            cnt_q    <= cnt_d;
            shift_q  <= shift_d;
            dout_q   <= dout_d;
            done_q   <= done_d;
            abort_q  <= abort_d;
        end
    end

    assign LINK.dout   = dout_q;
    assign FRAME_DONE  = done_q;
    assign FRAME_ABORT = abort_q;

    // ==========================================================
    // Command executor
    logic [CW-1:0] reg_q [CH];
    logic [CW-1:0] reg_d [CH];
    logic [CW-1:0] out_q [CH];
    logic [CW-1:0] out_d [CH];
    logic [CH-1:0] pd_q, pd_d;
    logic [CH-1:0] wake_q, wake_d;
    logic          mode_q, mode_d;
    logic [CH*CW-1:0] level_q, level_d;
    logic [3:0]    nib;
    logic [2:0]    sel;
    logic [CW-1:0] code;
    logic [CH-1:0] touched;

    // After a long frame the last sixteen bits shifted are the command
    always_comb begin
        nib     = shift_q[ods_pkg::CMD_MSB:ods_pkg::CMD_LSB];
        sel     = shift_q[ods_pkg::SEL_MSB:ods_pkg::SEL_LSB];
        code    = shift_q[ods_pkg::CODE_MSB:0];
        mode_d  = mode_q;
        pd_d    = pd_q;
        touched = '0;
        for (int i = 0; i < CH; i++) begin
            reg_d[i] = reg_q[i];
            out_d[i] = out_q[i];
        end
        if (exec) begin
            if (!nib[3]) begin
                reg_d[sel] = code;
                if (mode_q) begin
                    out_d[sel]   = code;
                    touched[sel] = 1'b1;
                end
            end else begin
                case (nib)
                    ods_pkg::CMD_REG_ONLY:  mode_d = 1'b0;
                    ods_pkg::CMD_IMMEDIATE: mode_d = 1'b1;
                    ods_pkg::CMD_UPD_ALL: begin
                        for (int i = 0; i < CH; i++) begin
                            out_d[i] = reg_q[i];
                        end
                        touched = '1;
                    end
                    ods_pkg::CMD_LOAD_A: begin
                        reg_d[0] = code;
                        out_d[0] = code;
                        for (int i = 1; i < CH; i++) begin
                            out_d[i] = reg_q[i];
                        end
                        touched = '1;
                    end
                    ods_pkg::CMD_BROADCAST: begin
                        for (int i = 0; i < CH; i++) begin
                            reg_d[i] = code;
                            out_d[i] = code;
                        end
                        touched = '1;
                    end
                    ods_pkg::CMD_PWR_DOWN: begin
                        pd_d = pd_q | code[ods_pkg::PD_MASK_MSB:0];
                    end
                    default: begin
                        mode_d = mode_q;
                    end
                endcase
            end
            // An updated output leaves power-down at this sync rise
            pd_d = pd_d & ~touched;
        end
        wake_d = pd_q & touched;
        for (int i = 0; i < CH; i++) begin
            // Powered-down channels sit at zero
            level_d[i*CW +: CW] = pd_d[i] ? '0 : out_d[i];
        end
    end

    // Executor registers; an aborted frame never reaches here
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < CH; i++) begin
                reg_q[i] <= '0;
                out_q[i] <= '0;
            end
            pd_q    <= {CH{ods_pkg::RST_PWR_DOWN}};
            wake_q  <= '0;
            mode_q  <= ods_pkg::RST_IMM_MODE;
            level_q <= '0;
        end else begin
            for (int i = 0; i < CH; i++) begin
                reg_q[i] <= reg_d[i];
                out_q[i] <= out_d[i];
            end
            pd_q    <= pd_d;
            wake_q  <= wake_d;
            mode_q  <= mode_d;
            level_q <= level_d;
        end
    end

    assign LEVEL_OUT = level_q;
    assign PWR_DOWN  = pd_q;
    assign WAKE      = wake_q;
    assign IMM_MODE  = mode_q;
endmodule : ods_dev

/* hdl/ods_host.sv */
// Host end: word buffer and serial frame sequencer
`timescale 1ns/1ps
module ods_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // Drain side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]  cnt_q, cnt_d;
    logic         rdy_q, rdy_d;
    logic         push, pop;

    // Pointers wrap at DEPTH; ready is registered from the next count
    always_comb begin
        push  = in_valid && rdy_q;
        pop   = out_ready && (cnt_q != '0);
        wp_d  = push ? ((wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1) : wp_q;
        rp_d  = pop ? ((rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        rdy_d = (cnt_d != (AW + 1)'(DEPTH));
    end

    // Storage and pointers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            if (push) begin
                mem_q[wp_q] <= in_data;
            end
        end
    end

    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
endmodule : ods_fifo

module ods_host #(
    parameter int HALF_CYC   = ods_pkg::HALF_CYC,
    parameter int GAP_HALVES = ods_pkg::GAP_HALVES
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // Word input
    input  wire logic [15:0] WORD_DATA,
    input  wire logic        WORD_VALID,
    output logic             WORD_READY,
    // Status
    output logic             BUSY,
    // Serial link
    ods_link_if.host         LINK
);
    // ==========================================================
    // Word buffer; drained only when the sequencer is idle
    logic [15:0] buf_data;
    logic        buf_valid, buf_ready;

    ods_fifo #(.W(16), .DEPTH(2)) u_buf (
        .clk       (CLK),
        .rst       (SYS_RST),
        .in_data   (WORD_DATA),
        .in_valid  (WORD_VALID),
        .in_ready  (WORD_READY),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready)
    );

    // ==========================================================
    // Half-period divider and frame sequencer
    ods_pkg::ods_host_st_t st_q, st_d;
    logic [7:0]  div_q, div_d;
    logic [15:0] word_q, word_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  gap_q, gap_d;
    logic        sclk_q, sclk_d, sync_q, sync_d, din_q, din_d;
    logic        tick, busy_q, busy_d;

    // Every link edge lands on a tick, so sync never moves with a fall
    always_comb begin
        tick      = (div_q == 8'(HALF_CYC - 1));
        div_d     = tick ? 8'h00 : div_q + 8'h01;
        st_d      = st_q;
        word_d    = word_q;
        bit_d     = bit_q;
        gap_d     = gap_q;
        sclk_d    = sclk_q;
        sync_d    = sync_q;
        din_d     = din_q;
        buf_ready = 1'b0;
        case (st_q)
            ods_pkg::HS_IDLE: begin
                if (tick && buf_valid) begin
                    buf_ready = 1'b1;
                    word_d    = buf_data;
                    sync_d    = 1'b0;
                    din_d     = buf_data[15];
                    bit_d     = 4'h0;
                    st_d      = ods_pkg::HS_LEAD;
                end
            end
            ods_pkg::HS_LEAD, ods_pkg::HS_HIGH: begin
                if (tick) begin
                    sclk_d = 1'b0;
                    st_d   = ods_pkg::HS_LOW;
                end
            end
            ods_pkg::HS_LOW: begin
                if (tick) begin
                    sclk_d = 1'b1;
                    if (bit_q == 4'hf) begin
                        din_d = 1'b0;
                        st_d  = ods_pkg::HS_TAIL;
                    end else begin
                        bit_d  = bit_q + 4'h1;
                        din_d  = word_q[14];
                        word_d = {word_q[14:0], 1'b0};
                        st_d   = ods_pkg::HS_HIGH;
                    end
                end
            end
            ods_pkg::HS_TAIL: begin
                if (tick) begin
                    sync_d = 1'b1;
                    gap_d  = 8'h00;
                    st_d   = ods_pkg::HS_GAP;
                end
            end
            ods_pkg::HS_GAP: begin
                if (tick) begin
                    gap_d = gap_q + 8'h01;
                    if (gap_q == 8'(GAP_HALVES - 1)) begin
                        st_d = ods_pkg::HS_IDLE;
                    end
                end
            end
            default: begin
                st_d   = ods_pkg::HS_IDLE;
                sync_d = 1'b1;
                sclk_d = 1'b1;
            end
        endcase
        // Status follows the next state so the flop matches the state register
        busy_d = (st_d != ods_pkg::HS_IDLE);
    end

    // Sequencer registers; pins idle with sync high and data low
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q   <= ods_pkg::HS_IDLE;
            div_q  <= 8'h00;
            word_q <= 16'h0000;
            bit_q  <= 4'h0;
            gap_q  <= 8'h00;
            sclk_q <= 1'b1;
            sync_q <= 1'b1;
            din_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            div_q  <= div_d;
            word_q <= word_d;
            bit_q  <= bit_d;
            gap_q  <= gap_d;
            sclk_q <= sclk_d;
            sync_q <= sync_d;
            din_q  <= din_d;
            busy_q <= busy_d;
        end
    end

    assign LINK.sclk   = sclk_q;
    assign LINK.sync_n = sync_q;
    assign LINK.din    = din_q;
    assign BUSY        = busy_q;
endmodule : ods_host

/* verif/ods_link_asserts.sv */
// Checker for the joined link: framing and chain output timing
`timescale 1ns/1ps
module ods_link_asserts (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Link wires
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic din,
    input wire logic dout
);
    // ==========================================================
    // Helper state
    logic [4:0] cnt_q, cnt_d;
    logic       sclk_q, sync_q, first_q, first_d;

    // Falls in the frame; the first bit is kept to check the echo
    always_comb begin
        cnt_d   = cnt_q;
        first_d = first_q;
        if (sync_q && !sync_n) begin
            cnt_d = 5'h00;
        end else if (!sync_n && sclk_q && !sclk) begin
            cnt_d   = cnt_q + 5'h01;
            first_d = (cnt_q == 5'h00) ? din : first_q;
        end
    end

    // Cleared by reset so a reset in mid-frame leaves no stale count
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cnt_q   <= 5'h00;
            sclk_q  <= 1'b1;
            sync_q  <= 1'b1;
            first_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            sclk_q  <= sclk;
            sync_q  <= sync_n;
            first_q <= first_d;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    property p_sync_setup; $fell(sync_n) |-> sclk[*3]; endproperty
    property p_frame_len; $rose(sync_n) |-> cnt_q == 5'h10; endproperty
    property p_no_17th; !sync_n && cnt_q == 5'h10 |-> !$fell(sclk); endproperty
    property p_sync_gap; $rose(sync_n) |-> sync_n[*8]; endproperty
    property p_din_idle; sync_n |-> !din; endproperty
    property p_dout_low; $fell(sclk) && !sync_n && cnt_q < 5'h0e |-> ##5 !dout; endproperty
    property p_dout_mark; $fell(sclk) && !sync_n && cnt_q == 5'h0e |-> ##5 dout; endproperty
    property p_dout_echo;
        $fell(sclk) && !sync_n && cnt_q == 5'h0f |-> ##5 (dout == first_q);
    endproperty
    property p_dout_quiet; sync_n[*5] |-> !dout; endproperty

    a_sync_setup: assert property (p_sync_setup) else $error("sync fell near clock fall");
    a_frame_len: assert property (p_frame_len) else $error("frame not 16 falls");
    a_no_17th: assert property (p_no_17th) else $error("17th fall in frame");
    a_sync_gap: assert property (p_sync_gap) else $error("sync high too short");
    a_din_idle: assert property (p_din_idle) else $error("data high while idle");
    a_dout_low: assert property (p_dout_low) else $error("chain out not low");
    a_dout_mark: assert property (p_dout_mark) else $error("chain out no mark");
    a_dout_echo: assert property (p_dout_echo) else $error("chain out bad echo");
    a_dout_quiet: assert property (p_dout_quiet) else $error("chain out active idle");

    // Main scenarios reached
    c_frame: cover property ($rose(sync_n) && cnt_q == 5'h10);
    c_mark: cover property ($rose(dout));
    c_back: cover property ($rose(sync_n) ##[8:40] $fell(sync_n));
endmodule : ods_link_asserts

/* verif/tb_octal_dac_serial_input.sv */
// Bench: host and converter ends joined, plus a hand-driven fault link
`timescale 1ns/1ps
module tb_octal_dac_serial_input;
    // ==========================================================
    // Signals and model
    logic        clk, rst, word_valid, word_ready, busy;
    logic [15:0] word_data, cap_a;
    logic [95:0] level_a, level_b;
    logic [7:0]  pwr_a, wake_a, pwr_b, pd_m, pd_old;
    logic        imm_a, done_a, abort_a, done_b, abort_b, imm_m, sclk_p, sync_p;
    logic [31:0] dob;
    logic [11:0] reg_m[8];
    logic [11:0] out_m[8];
    logic [15:0] exp_q[$];
    int          mismatches, compares, n_done_b, n_abort_b;

    ods_link_if link_a();
    ods_link_if link_b();
    ods_host u_ods_host (.CLK(clk), .SYS_RST(rst), .WORD_DATA(word_data),
        .WORD_VALID(word_valid), .WORD_READY(word_ready), .BUSY(busy), .LINK(link_a));
    ods_dev u_ods_dev (.CLK(clk), .SYS_RST(rst), .LINK(link_a), .LEVEL_OUT(level_a),
        .PWR_DOWN(pwr_a), .WAKE(wake_a), .IMM_MODE(imm_a), .FRAME_DONE(done_a),
        .FRAME_ABORT(abort_a));
    // Second converter on a link the bench drives, for broken frames
    ods_dev u_ods_dev_b (.CLK(clk), .SYS_RST(rst), .LINK(link_b), .LEVEL_OUT(level_b),
        .PWR_DOWN(pwr_b), .WAKE(), .IMM_MODE(), .FRAME_DONE(done_b),
        .FRAME_ABORT(abort_b));
    ods_link_asserts u_ods_link_asserts (.CLK(clk), .SYS_RST(rst), .sclk(link_a.sclk),
        .sync_n(link_a.sync_n), .din(link_a.din), .dout(link_a.dout));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================================
    // Report and compare
    task automatic end_sim();
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Expected converter state after one executed word
    function automatic void apply(input logic [15:0] w);
        case (w[15:12])
            4'h8: imm_m = 1'b0;
            4'h9: imm_m = 1'b1;
            4'ha, 4'hb, 4'hc: begin
                for (int i = 0; i < 8; i++) begin
                    if (w[15:12] == 4'hc || (w[15:12] == 4'hb && i == 0)) reg_m[i] = w[11:0];
                    out_m[i] = reg_m[i];
                end
                pd_m = 8'h00;
            end
            4'hd: pd_m = pd_m | w[7:0];
            default: if (!w[15]) begin
                reg_m[w[14:12]] = w[11:0];
                if (imm_m) out_m[w[14:12]] = w[11:0];
                if (imm_m) pd_m[w[14:12]] = 1'b0;
            end
        endcase
    endfunction : apply

    function automatic logic [95:0] lvl();
        for (int i = 0; i < 8; i++) lvl[i*12+:12] = pd_m[i] ? 12'h000 : out_m[i];
    endfunction : lvl

    // Scoreboard: wire bits at sync rise, converter outputs at frame end
    always @(posedge clk) begin
        sclk_p <= link_a.sclk;
        sync_p <= link_a.sync_n;
        if (!link_a.sync_n && sclk_p && !link_a.sclk) cap_a <= {cap_a[14:0], link_a.din};
        if (link_a.sync_n && !sync_p && exp_q.size() > 0) chk(cap_a, exp_q[0]);
        if (abort_a === 1'b1) chk(abort_a, 1'b0);
        if (done_b === 1'b1) n_done_b++;
        if (abort_b === 1'b1) n_abort_b++;
        if (done_a === 1'b1 && exp_q.size() == 0) chk(done_a, 1'b0);
        if (done_a === 1'b1 && exp_q.size() > 0) begin
            pd_old = pd_m;
            apply(exp_q.pop_front());
            chk(level_a, lvl());
            chk(pwr_a, pd_m);
            chk(wake_a, pd_old & ~pd_m);
            chk(imm_a, imm_m);
        end
    end

    // ==========================================================
    // Drivers
    task automatic send(input logic [15:0] w, inout int stalls);
        exp_q.push_back(w);
        @(posedge clk);
        word_valid <= 1'b1;
        word_data  <= w;
        for (int i = 0; i <= 500; i++) begin
            @(posedge clk);
            if (word_ready === 1'b1) break;
            stalls++;
            if (i == 500) chk(word_ready, 1'b1);
            if (i == 500) end_sim();
        end
        word_valid <= 1'b0;
    endtask : send

    task automatic drain();
        for (int i = 0; i <= 5000; i++) begin
            @(posedge clk);
            if (exp_q.size() == 0 && busy === 1'b0) return;
        end
        chk(exp_q.size(), 0);
        end_sim();
    endtask : drain

    // Fault link: nf falls of the stream s, chain output read before each next fall
    task automatic frame_b(input logic [31:0] s, input int nf);
        @(posedge clk);
        link_b.sync_n <= 1'b0;
        link_b.din    <= s[31];
        repeat (4) @(posedge clk);
        for (int k = 1; k <= nf; k++) begin
            link_b.sclk <= 1'b0;
            repeat (4) @(posedge clk);
            link_b.sclk <= 1'b1;
            link_b.din  <= (k < 32) ? s[31-k] : 1'b0;
            repeat (3) @(posedge clk);
            dob[32-k] = link_b.dout;
            @(posedge clk);
        end
        link_b.sync_n <= 1'b1;
        link_b.din    <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : frame_b

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk(pwr_a, 8'hff);
        chk(imm_a, 1'b0);
        chk(level_a, 96'h0);
        chk({link_a.sclk, link_a.sync_n, link_a.din, link_a.dout}, 4'hc);
        chk({word_ready, busy}, 2'h2);
    endtask : t_reset

    // Channel writes back to back fill the buffer, then one update shows all
    task automatic t_reg_only();
        int s;
        s = 0;
        for (int ch = 0; ch < 8; ch++) send({1'b0, 3'(ch), 12'(4095 - ch * 585)}, s);
        send(16'ha000, s);
        drain();
        chk(96'(s != 0), 96'h1);
    endtask : t_reg_only

    task automatic t_modes();
        logic [15:0] seq[9];
        int          s;
        seq = '{16'h9000, 16'h3800, 16'hd0a5, 16'h8000, 16'h3123,
                16'ha000, 16'hb0ff, 16'hf123, 16'hc5a5};
        s = 0;
        foreach (seq[i]) send(seq[i], s);
        drain();
    endtask : t_modes

    task automatic t_chain();
        int d;
        d = n_done_b;
        frame_b({16'h9abc, 16'hc5a5}, 32);
        chk(dob, {14'h0, 1'b1, 16'h9abc, 1'b1});
        chk(n_done_b - d, 1);
        chk(level_b, {8{12'h5a5}});
        chk(pwr_b, 8'h00);
    endtask : t_chain

    task automatic t_abort();
        int nf[3];
        int a;
        nf = '{1, 14, 15};
        foreach (nf[i]) begin
            a = n_abort_b;
            frame_b(32'hc000_0000, nf[i]);
            chk(n_abort_b - a, 1);
            chk(level_b, {8{12'h5a5}});
        end
    endtask : t_abort

    initial begin
        rst = 1'b1;
        word_valid = 1'b0;
        word_data = 16'h0000;
        link_b.sclk = 1'b1;
        link_b.sync_n = 1'b1;
        link_b.din = 1'b0;
        mismatches = 0;
        compares = 0;
        n_done_b = 0;
        n_abort_b = 0;
        pd_m = 8'hff;
        imm_m = 1'b0;
        reg_m = '{default: 12'h000};
        out_m = '{default: 12'h000};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_reg_only();
        t_modes();
        t_chain();
        t_abort();
        end_sim();
    end
endmodule : tb_octal_dac_serial_input
